// file: cfg_field_reg.sv
// one writable configuration field, loadable by the host or by the eeprom
`timescale 1ns/100ps
`default_nettype none

module cfg_field_reg #(
  parameter int W = 1,
  parameter int LSB = 0,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and global reset
  input wire logic clk_in,
  input wire logic rst_in,
  // host write, already decoded to this register
  input wire logic host_we_in,
  input wire logic [3:0] host_be_in,
  input wire logic [31:0] host_wdata_in,
  // eeprom load, already decoded to this register
  input wire logic load_we_in,
  input wire logic [31:0] load_data_in,
  // stored field
  output logic [W-1:0] q_out
);

  // byte lane that carries this field; fields never straddle lanes
  localparam int LANE = LSB / 8;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // only the global reset loads RST_VAL; eeprom load wins a same-cycle clash
  // because the loader only runs right after reset, before host software
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_out <= RST_VAL;
    end else if (load_we_in) begin
      q_out <= load_data_in[LSB +: W];
    end else if (host_we_in && host_be_in[LANE]) begin
      q_out <= host_wdata_in[LSB +: W];
    end
  end

endmodule
`default_nettype wire

// file: smart_card_cfg_pkg.sv
// shared offsets, field layout, reset values and carriers for the socket configuration registers
package smart_card_cfg_pkg;

  // ----------------------------------------------------------------
  // configuration-space offsets of the two registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_CFG_OFS = 8'h58; // socket_capability_config
  localparam logic [7:0] PWR_CFG_OFS = 8'h54; // socket_power_delay_config

  // ----------------------------------------------------------------
  // values after global reset
  // ----------------------------------------------------------------
  localparam logic [31:0] CAP_CFG_RST = 32'h01101101;
  localparam logic [31:0] PWR_CFG_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // field positions of socket_capability_config
  // ----------------------------------------------------------------
  localparam int SCRATCH_LSB = 28; // scratch_nibble, four bits
  localparam int SCRATCH_W = 4;
  localparam int CLASS_B_BIT = 24; // volt_class_b_support_s0
  localparam int CLASS_A_BIT = 20; // volt_class_a_support_s0
  localparam int PAY_IF_BIT = 16; // payment_iface_enable_s0
  localparam int GEN_PINS_BIT = 12; // general_pins_enable_s0
  localparam int LEG_MODE_BIT = 8; // legacy_card_mode_s0
  localparam int WAKE_BIT = 4; // insert_wake_enable_s0
  localparam int SKT_EN_BIT = 0; // socket_zero_enable

  // ----------------------------------------------------------------
  // field positions of socket_power_delay_config
  // ----------------------------------------------------------------
  localparam int PWR_DLY_LSB = 8; // legacy_socket_power_delay, in ms
  localparam int PWR_DLY_W = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // one configuration-space access from the host
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // one word from the serial eeprom loader
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [31:0] data;
  } eeprom_word_t;

  // settings that steer the smart card socket logic
  typedef struct packed {
    logic socket_en;
    logic payment_iface_en;
    logic general_pins_en;
    logic legacy_card_mode;
    logic insert_wake_en;
    logic class_a_support;
    logic class_b_support;
  } socket_ctrl_t;

endpackage

// file: smart_card_socket_config_regs.sv
// socket capability and power-delay configuration registers of the smart card function
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R1: capability register at 0x58, resets 0x01101101
// R2: power delay register at 0x54, resets zero
// R3: only global reset restores defaults
// R4: capability reserved fields read zero, ignore writes
// R5: bit 24 advertises class b support
// R6: bit 20 advertises class a support
// R7: bit 16 enables payment card interface
// R8: bit 12 enables socket general pins
// R9: software sets bit 8 equal to strap
// R10: bit 4 raises wake event on insertion
// R11: bit 0 enables socket zero
// R12: absent socket bits hard-wired zero, unwritable
// R13: capability register readable through global mirror
// R14: power delay register readable through global mirror
// R15: bits 15-8 report power delay in ms, host read-only
// R16: power delay field steers no hardware
// R17: software waits reported delay before socket use
// R18: power delay bits 31-16, 7-0 read zero
// R19: bits 31-28 are a free scratch nibble
// R20: writable fields load from host or eeprom
module smart_card_socket_config_regs (
  // clock and global reset
  input wire logic clk_in,
  input wire logic rst_in,
  // configuration-space access from the host
  input wire smart_card_cfg_pkg::cfg_req_t cfg_req_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  output logic cfg_hit_out,
  // serial eeprom load after global reset
  input wire smart_card_cfg_pkg::eeprom_word_t eeprom_word_in,
  // socket events
  input wire logic card_insert_in,
  output logic insert_wake_event_out,
  // settings toward the socket logic
  output smart_card_cfg_pkg::socket_ctrl_t socket_ctrl_out,
  // mirrors for the global control register set
  output logic [31:0] cap_mirror_out,
  output logic [31:0] pwr_mirror_out
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic cap_sel; // host access targets the capability register
  logic pwr_sel; // host access targets the power delay register
  logic cap_host_we; // host write to the capability register
  logic cap_load_we; // eeprom word for the capability register
  logic pwr_load_we; // eeprom word for the power delay register

  // offsets decoded on the full byte address of the dword
  always_comb begin
    cap_sel = (cfg_req_in.addr == smart_card_cfg_pkg::CAP_CFG_OFS); // R1
    pwr_sel = (cfg_req_in.addr == smart_card_cfg_pkg::PWR_CFG_OFS); // R2
    cap_host_we = cfg_req_in.wr && cap_sel;
    cap_load_we = eeprom_word_in.we &&
                  (eeprom_word_in.addr == smart_card_cfg_pkg::CAP_CFG_OFS); // R20
    pwr_load_we = eeprom_word_in.we &&
                  (eeprom_word_in.addr == smart_card_cfg_pkg::PWR_CFG_OFS); // R20
  end

  // ----------------------------------------------------------------
  // capability register fields
  // ----------------------------------------------------------------
  logic [3:0] scratch_nibble; // free storage for firmware
  logic volt_class_b_support_s0; // advertises class b cards
  logic volt_class_a_support_s0; // advertises class a cards
  logic payment_iface_enable_s0; // turns on payment card interface
  logic general_pins_enable_s0; // turns on socket general pins
  logic legacy_card_mode_s0; // socket wired as legacy card socket
  logic insert_wake_enable_s0; // insertion raises wake event
  logic socket_zero_enable; // socket 0 on

  // scratch nibble: stored and returned, read by nothing else
  cfg_field_reg #(
    .W(smart_card_cfg_pkg::SCRATCH_W),
    .LSB(smart_card_cfg_pkg::SCRATCH_LSB),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::SCRATCH_LSB +:
             smart_card_cfg_pkg::SCRATCH_W])
  ) u_scratch ( // R19
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(scratch_nibble)
  );

  // class b support flag, advertised and passed to the socket logic
  cfg_field_reg #(
    .W(1),
    .LSB(smart_card_cfg_pkg::CLASS_B_BIT),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::CLASS_B_BIT])
  ) u_class_b ( // R5
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(volt_class_b_support_s0)
  );

  // class a support flag, advertised and passed to the socket logic
  cfg_field_reg #(
    .W(1),
    .LSB(smart_card_cfg_pkg::CLASS_A_BIT),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::CLASS_A_BIT])
  ) u_class_a ( // R6
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(volt_class_a_support_s0)
  );

  // payment card interface enable
  cfg_field_reg #(
    .W(1),
    .LSB(smart_card_cfg_pkg::PAY_IF_BIT),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::PAY_IF_BIT])
  ) u_pay_if ( // R7
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(payment_iface_enable_s0)
  );

  // general pins enable
  cfg_field_reg #(
    .W(1),
    .LSB(smart_card_cfg_pkg::GEN_PINS_BIT),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::GEN_PINS_BIT])
  ) u_gen_pins ( // R8
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(general_pins_enable_s0)
  );

  // legacy card mode; no check against the strap here, software must
  // keep the two equal, so a mismatch simply passes through
  cfg_field_reg #(
    .W(1),
    .LSB(smart_card_cfg_pkg::LEG_MODE_BIT),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::LEG_MODE_BIT])
  ) u_leg_mode ( // R9
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(legacy_card_mode_s0)
  );

  // wake-on-insertion enable
  cfg_field_reg #(
    .W(1),
    .LSB(smart_card_cfg_pkg::WAKE_BIT),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::WAKE_BIT])
  ) u_wake ( // R10
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(insert_wake_enable_s0)
  );

  // socket 0 enable
  cfg_field_reg #(
    .W(1),
    .LSB(smart_card_cfg_pkg::SKT_EN_BIT),
    .RST_VAL(smart_card_cfg_pkg::CAP_CFG_RST[smart_card_cfg_pkg::SKT_EN_BIT])
  ) u_skt_en ( // R11
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(cap_host_we),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(cap_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(socket_zero_enable)
  );

  // ----------------------------------------------------------------
  // power delay register field
  // ----------------------------------------------------------------
  logic [7:0] legacy_socket_power_delay; // switch settling time in ms

  // host writes never reach it: the host write strobe is tied low
  cfg_field_reg #(
    .W(smart_card_cfg_pkg::PWR_DLY_W),
    .LSB(smart_card_cfg_pkg::PWR_DLY_LSB),
    .RST_VAL(smart_card_cfg_pkg::PWR_CFG_RST[smart_card_cfg_pkg::PWR_DLY_LSB +:
             smart_card_cfg_pkg::PWR_DLY_W])
  ) u_pwr_dly ( // R15
    .clk_in(clk_in),
    .rst_in(rst_in), // R3
    .host_we_in(1'b0),
    .host_be_in(cfg_req_in.be),
    .host_wdata_in(cfg_req_in.wdata),
    .load_we_in(pwr_load_we),
    .load_data_in(eeprom_word_in.data),
    .q_out(legacy_socket_power_delay)
  );

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  logic [31:0] cap_image; // capability register as read
  logic [31:0] pwr_image; // power delay register as read

  // reserved bits and the bits of the absent second socket are
  // constant zero, so nothing is stored for them and writes vanish
  always_comb begin
    cap_image = 32'h00000000; // R4 R12
    cap_image[smart_card_cfg_pkg::SCRATCH_LSB +: smart_card_cfg_pkg::SCRATCH_W] =
      scratch_nibble;
    cap_image[smart_card_cfg_pkg::CLASS_B_BIT] = volt_class_b_support_s0;
    cap_image[smart_card_cfg_pkg::CLASS_A_BIT] = volt_class_a_support_s0;
    cap_image[smart_card_cfg_pkg::PAY_IF_BIT] = payment_iface_enable_s0;
    cap_image[smart_card_cfg_pkg::GEN_PINS_BIT] = general_pins_enable_s0;
    cap_image[smart_card_cfg_pkg::LEG_MODE_BIT] = legacy_card_mode_s0;
    cap_image[smart_card_cfg_pkg::WAKE_BIT] = insert_wake_enable_s0;
    cap_image[smart_card_cfg_pkg::SKT_EN_BIT] = socket_zero_enable;
  end

  // only the delay byte is live; everything around it reads zero
  always_comb begin
    pwr_image = 32'h00000000; // R18
    pwr_image[smart_card_cfg_pkg::PWR_DLY_LSB +: smart_card_cfg_pkg::PWR_DLY_W] =
      legacy_socket_power_delay;
  end

  // ----------------------------------------------------------------
  // configuration read path
  // ----------------------------------------------------------------
  logic [31:0] cfg_rdata_r; // read data held until the next read
  logic cfg_rvalid_r; // one-cycle read answer

  // answer one cycle after the read; unmapped offsets return zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_rdata_r <= 32'h00000000;
    end else if (cfg_req_in.rd) begin
      if (cap_sel) begin
        cfg_rdata_r <= cap_image; // R1
      end else if (pwr_sel) begin
        cfg_rdata_r <= pwr_image; // R2
      end else begin
        cfg_rdata_r <= 32'h00000000;
      end
    end
  end

  // read answer strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_rvalid_r <= 1'b0;
    end else begin
      cfg_rvalid_r <= cfg_req_in.rd;
    end
  end

  assign cfg_rdata_out = cfg_rdata_r;
  assign cfg_rvalid_out = cfg_rvalid_r;
  // claim the cycle so the function decoder can route the access
  assign cfg_hit_out = (cfg_req_in.rd || cfg_req_in.wr) && (cap_sel || pwr_sel);

  // ----------------------------------------------------------------
  // mirrors for the global control register set
  // ----------------------------------------------------------------
  logic [31:0] cap_mirror_r; // registered copy of the capability image
  logic [31:0] pwr_mirror_r; // registered copy of the power delay image

  // copies lag the registers by one cycle; the global set reads them
  // on its own schedule, so the extra cycle is harmless
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_mirror_r <= smart_card_cfg_pkg::CAP_CFG_RST;
      pwr_mirror_r <= smart_card_cfg_pkg::PWR_CFG_RST;
    end else begin
      cap_mirror_r <= cap_image; // R13
      pwr_mirror_r <= pwr_image; // R14
    end
  end

  assign cap_mirror_out = cap_mirror_r;
  assign pwr_mirror_out = pwr_mirror_r;

  // ----------------------------------------------------------------
  // settings toward the socket logic
  // ----------------------------------------------------------------
  // the power delay byte is deliberately absent: it times nothing
  always_comb begin
    socket_ctrl_out.socket_en = socket_zero_enable; // R11
    socket_ctrl_out.payment_iface_en = payment_iface_enable_s0; // R7
    socket_ctrl_out.general_pins_en = general_pins_enable_s0; // R8
    socket_ctrl_out.legacy_card_mode = legacy_card_mode_s0;
    socket_ctrl_out.insert_wake_en = insert_wake_enable_s0;
    socket_ctrl_out.class_a_support = volt_class_a_support_s0; // R6
    socket_ctrl_out.class_b_support = volt_class_b_support_s0; // R5
  end // R16

  // ----------------------------------------------------------------
  // wake event on card insertion
  // ----------------------------------------------------------------
  logic insert_wake_event_r; // one-cycle wake request

  // insertion pulse forwarded only while wake-on-insertion is enabled
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      insert_wake_event_r <= 1'b0;
    end else begin
      insert_wake_event_r <= card_insert_in && insert_wake_enable_s0; // R10
    end
  end

  assign insert_wake_event_out = insert_wake_event_r;

endmodule
`default_nettype wire

// file: smart_card_socket_config_regs_assertions.sv
// concurrent checks on the ports of the socket configuration registers
`timescale 1ns/100ps
`default_nettype none

module smart_card_socket_config_regs_assertions (
  // clock and global reset
  input wire logic clk_in,
  input wire logic rst_in,
  // configuration-space access
  input wire smart_card_cfg_pkg::cfg_req_t cfg_req_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_rvalid_out,
  input wire logic cfg_hit_out,
  // eeprom load
  input wire smart_card_cfg_pkg::eeprom_word_t eeprom_word_in,
  // socket events
  input wire logic card_insert_in,
  input wire logic insert_wake_event_out,
  // settings and mirrors
  input wire smart_card_cfg_pkg::socket_ctrl_t socket_ctrl_out,
  input wire logic [31:0] cap_mirror_out,
  input wire logic [31:0] pwr_mirror_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic [31:0] CAPW = 32'hf1111111; // writable capability bits
  logic cap_sel; // address names the capability register
  logic pwr_sel; // address names the power delay register
  assign cap_sel = (cfg_req_in.addr == smart_card_cfg_pkg::CAP_CFG_OFS);
  assign pwr_sel = (cfg_req_in.addr == smart_card_cfg_pkg::PWR_CFG_OFS);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // one answer pulse per read strobe, none otherwise
  property p_rvalid; 1 |=> cfg_rvalid_out == $past(cfg_req_in.rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer pulse wrong");
  // decode flag only for the two mapped offsets
  property p_hit;
    cfg_hit_out == ((cfg_req_in.rd || cfg_req_in.wr) && (cap_sel || pwr_sel));
  endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  // reserved capability bits never set
  property p_cap_resv; (cap_mirror_out & ~CAPW) == 32'h0; endproperty
  a_cap_resv: assert property (p_cap_resv) else $error("capability reserved set");
  // reserved power delay bits never set
  property p_pwr_resv; (pwr_mirror_out & 32'hffff00ff) == 32'h0; endproperty
  a_pwr_resv: assert property (p_pwr_resv) else $error("power reserved set");
  // read data and mirror come from the same image
  property p_rd_cap; cfg_req_in.rd && cap_sel |=> cfg_rdata_out == cap_mirror_out; endproperty
  a_rd_cap: assert property (p_rd_cap) else $error("capability mirror differs");
  property p_rd_pwr; cfg_req_in.rd && pwr_sel |=> cfg_rdata_out == pwr_mirror_out; endproperty
  a_rd_pwr: assert property (p_rd_pwr) else $error("power mirror differs");
  // unmapped reads answer zero
  property p_rd_none; cfg_req_in.rd && !cap_sel && !pwr_sel |=> cfg_rdata_out == 32'h0; endproperty
  a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
  // wake pulse follows an insertion only while enabled
  property p_wake;
    1 |=> insert_wake_event_out == $past(card_insert_in && socket_ctrl_out.insert_wake_en);
  endproperty
  a_wake: assert property (p_wake) else $error("wake event wrong");
  // socket, payment, pins and class settings are the stored bits, mirror one cycle behind
  property p_ctrl;
    1 |=> cap_mirror_out[0] == $past(socket_ctrl_out.socket_en)
      && cap_mirror_out[16] == $past(socket_ctrl_out.payment_iface_en)
      && cap_mirror_out[12] == $past(socket_ctrl_out.general_pins_en)
      && cap_mirror_out[20] == $past(socket_ctrl_out.class_a_support)
      && cap_mirror_out[24] == $past(socket_ctrl_out.class_b_support);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("settings differ from image");
endmodule

bind smart_card_socket_config_regs smart_card_socket_config_regs_assertions
  smart_card_socket_config_regs_assertions_inst (.clk_in, .rst_in, .cfg_req_in,
  .cfg_rdata_out, .cfg_rvalid_out, .cfg_hit_out, .eeprom_word_in, .card_insert_in,
  .insert_wake_event_out, .socket_ctrl_out, .cap_mirror_out, .pwr_mirror_out);

`default_nettype wire

// file: tb_smart_card_socket_config_regs.sv
// self-checking bench for the socket configuration registers
`timescale 1ns/100ps
`default_nettype none

module tb_smart_card_socket_config_regs;
  // ----------------------------------------------------------------
  // stimulus, observation and reference model
  // ----------------------------------------------------------------
  localparam logic [31:0] CAPW = 32'hf1111111; // writable capability bits
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  smart_card_cfg_pkg::cfg_req_t cfg_req_in = '0;
  smart_card_cfg_pkg::eeprom_word_t eeprom_word_in = '0;
  logic card_insert_in = 1'b0;
  logic [31:0] cfg_rdata_out;
  logic cfg_rvalid_out;
  logic cfg_hit_out;
  logic insert_wake_event_out;
  smart_card_cfg_pkg::socket_ctrl_t socket_ctrl_out;
  logic [31:0] cap_mirror_out;
  logic [31:0] pwr_mirror_out;
  logic [31:0] cap_exp; // expected capability image
  logic [31:0] pwr_exp; // expected power delay image
  logic [31:0] rd_val; // last read result
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  always #4 clk_in = ~clk_in;

  smart_card_socket_config_regs smart_card_socket_config_regs_inst (.clk_in(clk_in),
    .rst_in(rst_in), .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
    .cfg_rvalid_out(cfg_rvalid_out), .cfg_hit_out(cfg_hit_out),
    .eeprom_word_in(eeprom_word_in), .card_insert_in(card_insert_in),
    .insert_wake_event_out(insert_wake_event_out), .socket_ctrl_out(socket_ctrl_out),
    .cap_mirror_out(cap_mirror_out), .pwr_mirror_out(pwr_mirror_out));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hung handshake still ends the run with a verdict
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("timeout after %0d cycles", cycles);
      stop_test();
    end
  end

  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic smart_card_cfg_pkg::socket_ctrl_t ctrl_of(input logic [31:0] v);
    ctrl_of = '{v[0], v[16], v[12], v[8], v[4], v[20], v[24]};
  endfunction

  // read strobe for one cycle, answer sampled half a cycle after it is taken
  task automatic cfg_read(input logic [7:0] a, input logic hit, output logic [31:0] d);
    cfg_req_in.rd = 1'b1;
    cfg_req_in.addr = a;
    #1 check32("read hit", 32'(hit), 32'(cfg_hit_out));
    @(negedge clk_in);
    cfg_req_in.rd = 1'b0;
    check32("read valid", 32'h1, 32'(cfg_rvalid_out));
    d = cfg_rdata_out;
    // strobe stays low over one edge, so a following read is a fresh pulse
    @(negedge clk_in);
  endtask

  // write with byte lanes; model keeps only writable capability bits
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                           input logic hit);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & CAPW;
    cfg_req_in.wr = 1'b1;
    cfg_req_in.addr = a;
    cfg_req_in.be = be;
    cfg_req_in.wdata = d;
    #1 check32("write hit", 32'(hit), 32'(cfg_hit_out));
    @(negedge clk_in);
    cfg_req_in.wr = 1'b0;
    @(negedge clk_in);
    if (a == 8'h58) begin
      cap_exp = (cap_exp & ~m) | (d & m);
    end
  endtask

  // full word from the eeprom loader
  task automatic eeprom_load(input logic [7:0] a, input logic [31:0] d);
    eeprom_word_in.we = 1'b1;
    eeprom_word_in.addr = a;
    eeprom_word_in.data = d;
    @(negedge clk_in);
    eeprom_word_in.we = 1'b0;
    @(negedge clk_in);
    if (a == 8'h58) begin
      cap_exp = d & CAPW;
    end else if (a == 8'h54) begin
      pwr_exp = d & 32'h0000ff00;
    end
  endtask

  task automatic check_all(input string name);
    cfg_read(8'h58, 1'b1, rd_val);
    check32("cap read", cap_exp, rd_val);
    cfg_read(8'h54, 1'b1, rd_val);
    check32("pwr read", pwr_exp, rd_val);
    check32("cap mirror", cap_exp, cap_mirror_out);
    check32("pwr mirror", pwr_exp, pwr_mirror_out);
    check32("socket ctrl", 32'(ctrl_of(cap_exp)), 32'(socket_ctrl_out));
    $display("test %s done, fails so far %0d", name, fails);
  endtask

  // one insertion pulse, wake pulse expected or not
  task automatic wake_test(input logic exp);
    card_insert_in = 1'b1;
    @(negedge clk_in);
    card_insert_in = 1'b0;
    check32("wake pulse", 32'(exp), 32'(insert_wake_event_out));
    @(negedge clk_in);
    check32("wake end", 32'h0, 32'(insert_wake_event_out));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    cap_exp = 32'h01101101;
    pwr_exp = 32'h0;
    // delay reads zero here, so the socket may be used at once below
    check_all("reset values");
    cfg_write(8'h58, 4'hf, 32'hffffffff, 1'b1);
    check_all("write all ones");
    // successive lane writes touch only their own lanes
    cfg_write(8'h58, 4'h1, 32'h0, 1'b1);
    cfg_write(8'h58, 4'h8, 32'h5e000000, 1'b1);
    cfg_write(8'h58, 4'h6, 32'h00efef00, 1'b1);
    check_all("lane writes");
    wake_test(1'b0);
    cfg_write(8'h58, 4'h1, 32'h00000010, 1'b1);
    wake_test(1'b1);
    cfg_write(8'h54, 4'hf, 32'hffffffff, 1'b1);
    check_all("host write delay ignored");
    eeprom_load(8'h54, 32'hffffffff);
    // loaded word keeps bit 8 at one, matching a strap tied high
    eeprom_load(8'h58, 32'ha5a5a5a5);
    check_all("eeprom loads");
    eeprom_load(8'h50, 32'h0);
    cfg_write(8'h50, 4'hf, 32'h0, 1'b0);
    cfg_read(8'h50, 1'b0, rd_val);
    check32("unmapped read", 32'h0, rd_val);
    check_all("unmapped ignored");
    // eeprom and host hit the same register together: eeprom wins
    cfg_req_in.wr = 1'b1;
    cfg_req_in.addr = 8'h58;
    cfg_req_in.be = 4'hf;
    cfg_req_in.wdata = 32'h0;
    eeprom_word_in.we = 1'b1;
    eeprom_word_in.addr = 8'h58;
    eeprom_word_in.data = 32'h30000011;
    @(negedge clk_in);
    cfg_req_in.wr = 1'b0;
    eeprom_word_in.we = 1'b0;
    cap_exp = 32'h30000011;
    check_all("eeprom over host");
    // second reset in mid-run restores the defaults
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    cap_exp = 32'h01101101;
    pwr_exp = 32'h0;
    check_all("mid-run reset");
    stop_test();
  end
endmodule

`default_nettype wire
